// ===== pkg/nvm_access_regs.vh
`ifndef NVM_ACCESS_REGS_VH
`define NVM_ACCESS_REGS_VH

// Directly reachable special registers (any bank)
`define OFS_BYTE_INDEX 8'h1A
`define OFS_BYTE_VALUE 8'h1B
`define OFS_BANK_SELECTOR 8'h04
`define OFS_INDIRECT_POINTER_ONE 8'h03
`define OFS_INDIRECT_ACCESS_PORT_ONE 8'h02
`define OFS_IRQ_CONTROL 8'h0E

// Control register location behind the indirect port
`define CTL_INDIRECT_OFS 8'h40
`define CTL_BANK 1'h1

// Control register fields
`define CTL_FETCH_TRIG 0
`define CTL_FETCH_PERMIT 1
`define CTL_PROG_TRIG 2
`define CTL_PROG_PERMIT 3

// Interrupt control fields
`define IRQ_GLOBAL_EN 0
`define IRQ_NVM_EN 1
`define IRQ_NVM_FLAG 2

// Widths and reset values
`define INDEX_W 6
`define DATA_W 8
`define ARRAY_DEPTH 64
`define RESET_BYTE 8'h00
`define RESET_BIT 1'h0

// Write cycle length of the internal timer, in clock cycles
`define PROG_CYCLES 4000
`define PROG_CNT_W 12

`endif

// ===== verilog/nvm_cell_array.v
module nvm_cell_array #(
  parameter AW = 6,
  parameter DW = 8,
  parameter DEPTH = 64
) (
  input wire clk,
  input wire rst,
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [DW-1:0] wdata,
  input wire re,
  input wire [AW-1:0] raddr,
  output reg [DW-1:0] rdata
);
  reg [DW-1:0] cells [0:DEPTH-1];

  // Cells are not cleared by reset: contents persist
  always @(posedge clk) begin
    if (we) begin
      cells[waddr] <= wdata;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      rdata <= {DW{1'b0}};
    end else if (re) begin
      rdata <= cells[raddr];
    end
  end
endmodule

// ===== verilog/nvm_write_timer.v
module nvm_write_timer #(
  parameter CYCLES = 4000,
  parameter CW = 12
) (
  input wire clk,
  input wire rst,
  input wire start,
  output reg busy,
  output reg done
);
  reg [CW-1:0] count;

  always @(posedge clk) begin
    if (rst) begin
      busy <= 1'b0;
      done <= 1'b0;
      count <= {CW{1'b0}};
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        busy <= 1'b1;
        count <= CYCLES[CW-1:0] - {{(CW-1){1'b0}}, 1'b1};
      end else if (busy) begin
        if (count == {CW{1'b0}}) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          count <= count - {{(CW-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule

// ===== verilog/nvm_access_top.v
`include "nvm_access_regs.vh"

module nvm_access_top #(
  parameter PROG_CYCLES = `PROG_CYCLES
) (
  input wire CLOCK,
  input wire RST,
  input wire [7:0] BUS_ADDR,
  input wire BUS_WRITE,
  input wire BUS_READ,
  input wire [7:0] BUS_WDATA,
  output reg [7:0] BUS_RDATA,
  input wire STACK_FULL,
  input wire IRQ_SERVICED,
  output reg IRQ_REQUEST,
  output reg NVM_BUSY
);
  localparam ST_IDLE = 2'b00;
  localparam ST_FETCH = 2'b01;
  localparam ST_PROGRAM = 2'b10;

  reg [1:0] state;
  reg [1:0] next_state;

  reg [`INDEX_W-1:0] nvm_byte_index;
  reg [`DATA_W-1:0] nvm_byte_value;
  reg bank_selector;
  reg [7:0] indirect_pointer_one;
  reg program_permit;
  reg program_trigger;
  reg fetch_permit;
  reg fetch_trigger;
  reg global_irq_enable;
  reg nvm_irq_enable;
  reg nvm_irq_flag;

  reg [`INDEX_W-1:0] held_index;
  reg [`DATA_W-1:0] held_value;

  reg [7:0] read_mux;
  reg [`DATA_W-1:0] next_value;

  wire [`DATA_W-1:0] array_rdata;
  wire timer_busy;
  wire timer_done;

  wire ctl_selected;
  wire wr_index;
  wire wr_value;
  wire wr_bank;
  wire wr_pointer;
  wire wr_ctl;
  wire wr_irq;
  wire [7:0] ctl_view;
  wire start_fetch;
  wire start_program;
  wire fetch_finish;
  wire program_finish;

  // Control register visible only through the indirect port in bank one
  assign ctl_selected = (bank_selector == `CTL_BANK) &&
                        (indirect_pointer_one == `CTL_INDIRECT_OFS);

  assign wr_index = BUS_WRITE && (BUS_ADDR == `OFS_BYTE_INDEX);
  assign wr_value = BUS_WRITE && (BUS_ADDR == `OFS_BYTE_VALUE);
  assign wr_bank = BUS_WRITE && (BUS_ADDR == `OFS_BANK_SELECTOR);
  assign wr_pointer = BUS_WRITE && (BUS_ADDR == `OFS_INDIRECT_POINTER_ONE);
  assign wr_irq = BUS_WRITE && (BUS_ADDR == `OFS_IRQ_CONTROL);
  assign wr_ctl = BUS_WRITE && (BUS_ADDR == `OFS_INDIRECT_ACCESS_PORT_ONE) && ctl_selected;

  // Upper control bits are not implemented
  assign ctl_view = {4'h0, program_permit, program_trigger, fetch_permit, fetch_trigger};

  // Cycles start from the stored trigger only while permitted and idle
  assign start_fetch = (state == ST_IDLE) && fetch_trigger && fetch_permit;
  assign start_program = (state == ST_IDLE) && program_trigger && program_permit && !fetch_trigger;
  assign fetch_finish = (state == ST_FETCH);
  assign program_finish = (state == ST_PROGRAM) && timer_done;

  nvm_cell_array #(
    .AW(`INDEX_W),
    .DW(`DATA_W),
    .DEPTH(`ARRAY_DEPTH)
  ) u_array (
    .clk(CLOCK),
    .rst(RST),
    .we(program_finish),
    .waddr(held_index),
    .wdata(held_value),
    .re(start_fetch),
    .raddr(nvm_byte_index),
    .rdata(array_rdata)
  );

  nvm_write_timer #(
    .CYCLES(PROG_CYCLES),
    .CW(`PROG_CNT_W)
  ) u_timer (
    .clk(CLOCK),
    .rst(RST),
    .start(start_program),
    .busy(timer_busy),
    .done(timer_done)
  );

  // Sequencer
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start_fetch) begin
          next_state = ST_FETCH;
        end else if (start_program) begin
          next_state = ST_PROGRAM;
        end
      end
      ST_FETCH: begin
        next_state = ST_IDLE;
      end
      ST_PROGRAM: begin
        if (timer_done) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge CLOCK) begin
    if (RST) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Write target held for the whole write cycle
  always @(posedge CLOCK) begin
    if (RST) begin
      held_index <= {`INDEX_W{1'b0}};
      held_value <= `RESET_BYTE;
    end else if (start_program) begin
      held_index <= nvm_byte_index;
      held_value <= nvm_byte_value;
    end
  end

  // Index, bank and pointer registers
  always @(posedge CLOCK) begin
    if (RST) begin
      nvm_byte_index <= {`INDEX_W{1'b0}};
      bank_selector <= `RESET_BIT;
      indirect_pointer_one <= `RESET_BYTE;
    end else begin
      if (wr_index) begin
        nvm_byte_index <= BUS_WDATA[`INDEX_W-1:0];
      end
      if (wr_bank) begin
        bank_selector <= BUS_WDATA[0];
      end
      if (wr_pointer) begin
        indirect_pointer_one <= BUS_WDATA;
      end
    end
  end

  // Value register: a completed fetch wins over a software write
  always @* begin
    next_value = nvm_byte_value;
    if (wr_value) begin
      next_value = BUS_WDATA;
    end
    if (fetch_finish) begin
      next_value = array_rdata;
    end
  end

  always @(posedge CLOCK) begin
    if (RST) begin
      nvm_byte_value <= `RESET_BYTE;
    end else begin
      nvm_byte_value <= next_value;
    end
  end

  // Control register
  always @(posedge CLOCK) begin
    if (RST) begin
      program_permit <= `RESET_BIT;
      program_trigger <= `RESET_BIT;
      fetch_permit <= `RESET_BIT;
      fetch_trigger <= `RESET_BIT;
    end else begin
      if (wr_ctl) begin
        program_permit <= BUS_WDATA[`CTL_PROG_PERMIT];
        fetch_permit <= BUS_WDATA[`CTL_FETCH_PERMIT];
      end
      // Trigger sticks only if its permit is already high
      if (program_finish) begin
        program_trigger <= 1'b0;
      end else if (wr_ctl && (state == ST_IDLE) && !program_trigger && !fetch_trigger) begin
        program_trigger <= BUS_WDATA[`CTL_PROG_TRIG] && program_permit;
      end
      if (fetch_finish) begin
        fetch_trigger <= 1'b0;
      end else if (wr_ctl && (state == ST_IDLE) && !program_trigger && !fetch_trigger) begin
        fetch_trigger <= BUS_WDATA[`CTL_FETCH_TRIG] && fetch_permit;
      end
    end
  end

  // Interrupt enables and flag; the set from a finished write cycle wins over any clear
  always @(posedge CLOCK) begin
    if (RST) begin
      global_irq_enable <= `RESET_BIT;
      nvm_irq_enable <= `RESET_BIT;
      nvm_irq_flag <= `RESET_BIT;
    end else begin
      if (wr_irq) begin
        global_irq_enable <= BUS_WDATA[`IRQ_GLOBAL_EN];
        nvm_irq_enable <= BUS_WDATA[`IRQ_NVM_EN];
      end
      if (program_finish) begin
        nvm_irq_flag <= 1'b1;
      end else if (IRQ_SERVICED) begin
        nvm_irq_flag <= 1'b0;
      end else if (wr_irq) begin
        nvm_irq_flag <= BUS_WDATA[`IRQ_NVM_FLAG];
      end
    end
  end

  // Request toward the vectoring logic
  always @(posedge CLOCK) begin
    if (RST) begin
      IRQ_REQUEST <= 1'b0;
    end else begin
      IRQ_REQUEST <= nvm_irq_flag && nvm_irq_enable && global_irq_enable && !STACK_FULL &&
                     !IRQ_SERVICED;
    end
  end

  // Busy indicator for power management
  always @(posedge CLOCK) begin
    if (RST) begin
      NVM_BUSY <= 1'b0;
    end else begin
      NVM_BUSY <= (next_state != ST_IDLE) || timer_busy;
    end
  end

  // Read mux
  always @* begin
    read_mux = 8'h00;
    case (BUS_ADDR)
      `OFS_BYTE_INDEX: begin
        read_mux = {2'h0, nvm_byte_index};
      end
      `OFS_BYTE_VALUE: begin
        read_mux = nvm_byte_value;
      end
      `OFS_BANK_SELECTOR: begin
        read_mux = {7'h00, bank_selector};
      end
      `OFS_INDIRECT_POINTER_ONE: begin
        read_mux = indirect_pointer_one;
      end
      `OFS_INDIRECT_ACCESS_PORT_ONE: begin
        read_mux = ctl_selected ? ctl_view : 8'h00;
      end
      `OFS_IRQ_CONTROL: begin
        read_mux = {5'h00, nvm_irq_flag, nvm_irq_enable, global_irq_enable};
      end
      default: begin
        read_mux = 8'h00;
      end
    endcase
  end

  always @(posedge CLOCK) begin
    if (RST) begin
      BUS_RDATA <= 8'h00;
    end else if (BUS_READ) begin
      BUS_RDATA <= read_mux;
    end
  end
endmodule

// ===== bench/nvm_access_checker.sv
module nvm_access_checker #(
  parameter PROG_CYCLES = 4000
) (
  input wire CLOCK,
  input wire RST,
  input wire [7:0] BUS_ADDR,
  input wire BUS_WRITE,
  input wire BUS_READ,
  input wire [7:0] BUS_WDATA,
  input wire [7:0] BUS_RDATA,
  input wire STACK_FULL,
  input wire IRQ_SERVICED,
  input wire IRQ_REQUEST,
  input wire NVM_BUSY
);
  timeunit 1ns;
  timeprecision 1ns;
  reg [12:0] busy_len;
  always @(posedge CLOCK) begin
    if (RST || !NVM_BUSY) begin
      busy_len <= 13'h0000;
    end else begin
      busy_len <= busy_len + 13'h0001;
    end
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  property p_irq_cause;
    $rose(IRQ_REQUEST) |-> !$past(STACK_FULL) && !$past(IRQ_SERVICED);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("request without cause");
  property p_serviced;
    IRQ_SERVICED |=> !IRQ_REQUEST;
  endproperty
  a_serviced: assert property (p_serviced) else $error("request after service");
  property p_stack;
    STACK_FULL |=> !IRQ_REQUEST;
  endproperty
  a_stack: assert property (p_stack) else $error("request with stack full");
  property p_index_top;
    BUS_READ && BUS_ADDR == 8'h1A |=> BUS_RDATA[7:6] == 2'h0;
  endproperty
  a_index_top: assert property (p_index_top) else $error("index top bits set");
  property p_unmapped;
    BUS_READ && BUS_ADDR == 8'h7F |=> BUS_RDATA == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_hold;
    !BUS_READ |=> $stable(BUS_RDATA);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_start;
    $rose(NVM_BUSY) |-> $past(BUS_WRITE, 2) && $past(BUS_ADDR, 2) == 8'h02;
  endproperty
  a_start: assert property (p_start) else $error("cycle without trigger");
  property p_len;
    $fell(NVM_BUSY) |-> busy_len == 1 || (busy_len >= PROG_CYCLES + 1 && busy_len <= PROG_CYCLES + 2);
  endproperty
  a_len: assert property (p_len) else $error("cycle length wrong");
endmodule

// ===== bench/cpu_core_model.sv
module cpu_core_model (
  input wire CLOCK,
  input wire [7:0] BUS_RDATA,
  output reg [7:0] BUS_ADDR,
  output reg BUS_WRITE,
  output reg BUS_READ,
  output reg [7:0] BUS_WDATA
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    BUS_ADDR = 8'h00;
    BUS_WRITE = 1'b0;
    BUS_READ = 1'b0;
    BUS_WDATA = 8'h00;
  end
  // One-cycle strobe, data inverted once released
  task wr(input [7:0] a, input [7:0] v);
    begin
      @(posedge CLOCK);
      BUS_ADDR <= a;
      BUS_WDATA <= v;
      BUS_WRITE <= 1'b1;
      @(posedge CLOCK);
      BUS_WRITE <= 1'b0;
      BUS_WDATA <= ~v;
    end
  endtask
  task rd(input [7:0] a, output [7:0] v);
    begin
      @(posedge CLOCK);
      BUS_ADDR <= a;
      BUS_READ <= 1'b1;
      @(posedge CLOCK);
      BUS_READ <= 1'b0;
      @(negedge CLOCK);
      v = BUS_RDATA;
    end
  endtask
  // Control reached through bank one, pointer 40
  task sel_ctl;
    begin
      wr(8'h04, 8'h01);
      wr(8'h03, 8'h40);
    end
  endtask
endmodule

// ===== bench/tb_nvm_access_top.sv
module tb_nvm_access_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam P = 5;
  reg CLOCK = 1'b0;
  reg RST = 1'b1;
  reg STACK_FULL = 1'b0;
  reg IRQ_SERVICED = 1'b0;
  wire [7:0] BUS_ADDR;
  wire [7:0] BUS_WDATA;
  wire [7:0] BUS_RDATA;
  wire BUS_WRITE;
  wire BUS_READ;
  wire IRQ_REQUEST;
  wire NVM_BUSY;
  integer miscompares = 0;
  integer check_count = 0;
  reg [7:0] d;
  nvm_access_top #(.PROG_CYCLES(P)) nvm_access_top_inst (.CLOCK(CLOCK), .RST(RST), .BUS_ADDR(BUS_ADDR),
    .BUS_WRITE(BUS_WRITE), .BUS_READ(BUS_READ), .BUS_WDATA(BUS_WDATA), .BUS_RDATA(BUS_RDATA),
    .STACK_FULL(STACK_FULL), .IRQ_SERVICED(IRQ_SERVICED), .IRQ_REQUEST(IRQ_REQUEST), .NVM_BUSY(NVM_BUSY));
  cpu_core_model cpu_core_model_inst (.CLOCK(CLOCK), .BUS_RDATA(BUS_RDATA), .BUS_ADDR(BUS_ADDR),
    .BUS_WRITE(BUS_WRITE), .BUS_READ(BUS_READ), .BUS_WDATA(BUS_WDATA));
  initial begin
    forever #50 CLOCK = ~CLOCK;
  end
  task chk(input [7:0] g, input [7:0] e);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] v);
    cpu_core_model_inst.wr(a, v);
  endtask
  task rdchk(input [7:0] a, input [7:0] e);
    begin
      cpu_core_model_inst.rd(a, d);
      chk(d, e);
    end
  endtask
  task poll(input [7:0] m);
    integer i;
    begin
      d = m;
      for (i = 0; i < 50 && (d & m) != 8'h00; i = i + 1) cpu_core_model_inst.rd(8'h02, d);
      chk(d & m, 8'h00);
    end
  endtask
  task t_reset;
    begin
      rdchk(8'h1A, 8'h00);
      rdchk(8'h1B, 8'h00);
      rdchk(8'h0E, 8'h00);
      rdchk(8'h04, 8'h00);
      rdchk(8'h7F, 8'h00);
      rdchk(8'h02, 8'h00);
      cpu_core_model_inst.sel_ctl;
      rdchk(8'h02, 8'h00);
      wr(8'h02, 8'hF0);
      rdchk(8'h02, 8'h00);
      wr(8'h1A, 8'hFF);
      rdchk(8'h1A, 8'h3F);
      $display("test reset done");
    end
  endtask
  task t_blocked;
    begin
      wr(8'h02, 8'h01);
      rdchk(8'h02, 8'h00);
      wr(8'h02, 8'h04);
      rdchk(8'h02, 8'h00);
      wr(8'h02, 8'h08);
      wr(8'h02, 8'h00);
      wr(8'h02, 8'h04);
      rdchk(8'h02, 8'h00);
      chk({7'h00, NVM_BUSY}, 8'h00);
      $display("test blocked done");
    end
  endtask
  task t_write;
    begin
      wr(8'h1B, 8'hA5);
      wr(8'h0E, 8'h02);
      wr(8'h02, 8'h08);
      wr(8'h02, 8'h0C);
      rdchk(8'h02, 8'h0C);
      chk({7'h00, NVM_BUSY}, 8'h01);
      wr(8'h1B, 8'h3C);
      wr(8'h1A, 8'h00);
      poll(8'h04);
      chk({7'h00, IRQ_REQUEST}, 8'h00);
      rdchk(8'h0E, 8'h06);
      wr(8'h0E, 8'h07);
      @(posedge CLOCK);
      @(negedge CLOCK) chk({7'h00, IRQ_REQUEST}, 8'h01);
      @(posedge CLOCK) STACK_FULL <= 1'b1;
      @(posedge CLOCK);
      @(negedge CLOCK) chk({7'h00, IRQ_REQUEST}, 8'h00);
      @(posedge CLOCK) STACK_FULL <= 1'b0;
      @(posedge CLOCK) IRQ_SERVICED <= 1'b1;
      @(posedge CLOCK) IRQ_SERVICED <= 1'b0;
      rdchk(8'h0E, 8'h03);
      chk({7'h00, IRQ_REQUEST}, 8'h00);
      wr(8'h1A, 8'h3F);
      wr(8'h02, 8'h02);
      wr(8'h02, 8'h03);
      poll(8'h01);
      rdchk(8'h1B, 8'hA5);
      rdchk(8'h1A, 8'h3F);
      rdchk(8'h1B, 8'hA5);
      wr(8'h02, 8'h00);
      wr(8'h04, 8'h00);
      rdchk(8'h02, 8'h00);
      $display("test write done");
    end
  endtask
  task t_rerun;
    begin
      cpu_core_model_inst.sel_ctl;
      wr(8'h02, 8'h0A);
      rdchk(8'h02, 8'h0A);
      chk({7'h00, NVM_BUSY}, 8'h00);
      @(posedge CLOCK) RST <= 1'b1;
      repeat (4) @(posedge CLOCK);
      RST <= 1'b0;
      rdchk(8'h04, 8'h00);
      rdchk(8'h1B, 8'h00);
      rdchk(8'h1A, 8'h00);
      cpu_core_model_inst.sel_ctl;
      rdchk(8'h02, 8'h00);
      wr(8'h1A, 8'h3F);
      wr(8'h02, 8'h02);
      wr(8'h02, 8'h03);
      poll(8'h01);
      rdchk(8'h1B, 8'hA5);
      wr(8'h02, 8'h00);
      wr(8'h04, 8'h00);
      $display("test rerun done");
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
        $display("ALL TESTS PASSED");
      end else begin
        $display("TESTS FAILED");
      end
      $finish;
    end
  endtask
  initial begin
    repeat (4) @(posedge CLOCK);
    RST <= 1'b0;
    t_reset;
    t_blocked;
    t_write;
    t_rerun;
    tally_and_finish;
  end
  initial begin
    #300000;
    miscompares = miscompares + 1;
    tally_and_finish;
  end
endmodule
bind nvm_access_top nvm_access_checker #(.PROG_CYCLES(PROG_CYCLES)) nvm_access_checker_inst (.CLOCK(CLOCK),
  .RST(RST), .BUS_ADDR(BUS_ADDR), .BUS_WRITE(BUS_WRITE), .BUS_READ(BUS_READ), .BUS_WDATA(BUS_WDATA),
  .BUS_RDATA(BUS_RDATA), .STACK_FULL(STACK_FULL), .IRQ_SERVICED(IRQ_SERVICED), .IRQ_REQUEST(IRQ_REQUEST),
  .NVM_BUSY(NVM_BUSY));
